// *** src/tcr_regs.svh ***
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH
`define TCR_ADDR_UPPER_MSB  8'hA0
`define TCR_ADDR_UPPER_LSB  8'hA1
`define TCR_ADDR_LOWER_MSB  8'hA2
`define TCR_ADDR_LOWER_LSB  8'hA3
`define TCR_ADDR_TEMP_MSB   8'hAA
`define TCR_ADDR_TEMP_LSB   8'hAB
`define TCR_RST_TEMP        16'hE200
`define TCR_RST_UPPER       16'h0780
`define TCR_RST_LOWER       16'h0500
`define TCR_RST_RES         2'h3
`define TCR_LOW_ZERO_BITS   3
`define TCR_CONV10_MS       25
`define TCR_CLK_MHZ         100
`define TCR_CONV10_CYC      (`TCR_CONV10_MS * 1000 * `TCR_CLK_MHZ)
`endif

// *** src/tcr_pkg.sv ***
package tcr_pkg;
  typedef enum logic [2:0] {
    TCR_IDLE  = 3'b001,
    TCR_START = 3'b010,
    TCR_CONV  = 3'b100
  } tcr_state_t;
  typedef logic [1:0] tcr_res_t;
endpackage

// *** src/tcr_temp_conversion_readout.sv ***
`timescale 1ns/1ps
`include "tcr_regs.svh"
// Notes on behaviour
// - resolution 10..13 bits from two select bits
// - resolution defaults to 13 bits
// - each extra bit doubles conversion time
// - auto-run bit picks convert or standby
// - single-measure bit picks continuous or one-shot
// - continuous converts until halt, then standby
// - begin accepted anytime while stopped, resumes
// - one-shot: one conversion, power-up or begin
// - after one-shot, standby until next begin
// - 16-bit result, msb AAh, lsb ABh
// - bit 15 sign, bit 3 weighs 1/16
// - low three result bits read zero
// - result left-justified per resolution
// - thresholds two bytes, low bits dropped
// - threshold reset values 0780h and 0500h
// - result powers up holding E200h
module tcr_temp_conversion_readout #(
  parameter logic [31:0] CONV10_CYCLES = `TCR_CONV10_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        power_up_auto_run,
  input  wire logic        single_measure_select,
  input  wire logic        resolution_sel_lo,
  input  wire logic        resolution_sel_hi,
  input  wire logic        res_sel_wr,
  input  wire logic        begin_cmd,
  input  wire logic        halt_cmd,
  input  wire logic [15:0] sample_in,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             converting,
  output logic             result_done
);
  ////////////////////////////////////////////////////////////
  logic [1:0]  res_q;
  logic [15:0] temp_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [31:0] cnt_q;
  logic        boot_q;
  logic        run_q;
  logic [7:0]  rdata_d;
  logic [31:0] conv_len;
  logic [15:0] res_mask;
  logic        conv_end;
  tcr_pkg::tcr_state_t state_q;

  ////////////////////////////////////////////////////////////
  // resolution select
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      res_q <= `TCR_RST_RES;
    end else if (clk_en && res_sel_wr) begin
      res_q <= {resolution_sel_hi, resolution_sel_lo};
    end
  end

  // duration and mask per resolution
  always_comb begin
    conv_len = CONV10_CYCLES << res_q;
    res_mask = 16'hFFC0;
    case (res_q)
      2'h0: res_mask = 16'hFFC0;
      2'h1: res_mask = 16'hFFE0;
      2'h2: res_mask = 16'hFFF0;
      default: res_mask = 16'hFFF8;
    endcase
  end

  assign conv_end = (state_q == tcr_pkg::TCR_CONV) && (cnt_q >= conv_len - 32'h1);

  ////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= tcr_pkg::TCR_IDLE;
      boot_q  <= 1'b1;
      run_q   <= 1'b0;
      cnt_q   <= 32'h0;
    end else if (clk_en) begin
      boot_q <= 1'b0;
      case (state_q)
        tcr_pkg::TCR_IDLE: begin
          cnt_q <= 32'h0;
          if ((boot_q && power_up_auto_run) || begin_cmd) begin
            state_q <= tcr_pkg::TCR_START;
            run_q   <= !single_measure_select;
          end
        end
        tcr_pkg::TCR_START: begin
          cnt_q   <= 32'h0;
          state_q <= tcr_pkg::TCR_CONV;
        end
        tcr_pkg::TCR_CONV: begin
          cnt_q <= cnt_q + 32'h1;
          if (halt_cmd) begin
            run_q <= 1'b0;
          end
          if (conv_end) begin
            cnt_q <= 32'h0;
            if (run_q && !halt_cmd) begin
              state_q <= tcr_pkg::TCR_START;
            end else begin
              state_q <= tcr_pkg::TCR_IDLE;
            end
          end
        end
        default: state_q <= tcr_pkg::TCR_IDLE;
      endcase
    end
  end

  assign converting = (state_q != tcr_pkg::TCR_IDLE);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      result_done <= 1'b0;
    end else if (clk_en) begin
      result_done <= conv_end;
    end
  end

  ////////////////////////////////////////////////////////////
  // result register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      temp_q <= `TCR_RST_TEMP;
    end else if (clk_en) begin
      if (conv_end) begin
        temp_q <= sample_in & res_mask;
      end else if (reg_wr && reg_addr == `TCR_ADDR_TEMP_MSB) begin
        temp_q[15:8] <= reg_wdata;
      end else if (reg_wr && reg_addr == `TCR_ADDR_TEMP_LSB) begin
        temp_q[7:0] <= {reg_wdata[7:3], 3'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // thresholds
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      upper_q <= `TCR_RST_UPPER;
      lower_q <= `TCR_RST_LOWER;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `TCR_ADDR_UPPER_MSB) begin
        upper_q[15:8] <= reg_wdata;
      end else if (reg_addr == `TCR_ADDR_UPPER_LSB) begin
        upper_q[7:0] <= {reg_wdata[7:3], 3'h0};
      end else if (reg_addr == `TCR_ADDR_LOWER_MSB) begin
        lower_q[15:8] <= reg_wdata;
      end else if (reg_addr == `TCR_ADDR_LOWER_LSB) begin
        lower_q[7:0] <= {reg_wdata[7:3], 3'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // read port
  always_comb begin
    if (reg_addr == `TCR_ADDR_TEMP_MSB) begin
      rdata_d = temp_q[15:8];
    end else if (reg_addr == `TCR_ADDR_TEMP_LSB) begin
      rdata_d = {temp_q[7:3], 3'h0};
    end else if (reg_addr == `TCR_ADDR_UPPER_MSB) begin
      rdata_d = upper_q[15:8];
    end else if (reg_addr == `TCR_ADDR_UPPER_LSB) begin
      rdata_d = {upper_q[7:3], 3'h0};
    end else if (reg_addr == `TCR_ADDR_LOWER_MSB) begin
      rdata_d = lower_q[15:8];
    end else if (reg_addr == `TCR_ADDR_LOWER_LSB) begin
      rdata_d = {lower_q[7:3], 3'h0};
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
    end
  end
endmodule

// *** verif/tcr_asserts.sv ***
`timescale 1ns/1ps
module tcr_asserts #(
  parameter logic [31:0] CONV10_CYCLES = 32'h8
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic       power_up_auto_run,
  input wire logic       begin_cmd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       converting,
  input wire logic       result_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  begin_start_a: assert property (begin_cmd && !converting |=> converting) else $error("no start");
  stay_idle_a: assert property (!converting && !begin_cmd && !power_up_auto_run |=> !converting)
    else $error("spurious start");
  min_conv_a: assert property ($rose(converting) |-> !result_done [*8]) else $error("short conv");
  done_busy_a: assert property (result_done |-> $past(converting)) else $error("done idle");
  done_pulse_a: assert property (result_done |=> !result_done) else $error("long done");
  lsb_zero_a: assert property (reg_addr inside {8'hA1, 8'hA3, 8'hAB} |=> reg_rdata[2:0] == 3'h0)
    else $error("low bits set");
  unmapped_a: assert property (reg_addr == 8'hA8 |=> reg_rdata == 8'h00) else $error("unmapped");
  wr_back_a: assert property (reg_wr && reg_addr == 8'hA0 ##1 reg_addr == 8'hA0 |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("msb lost");
  freeze_hold_a: assert property (!clk_en |=> $stable(reg_rdata) && $stable(converting) && $stable(result_done))
    else $error("state moved while frozen");
endmodule
bind tcr_temp_conversion_readout tcr_asserts #(.CONV10_CYCLES(CONV10_CYCLES)) u_tcr_asserts (
  .ref_clk, .reset_n, .clk_en, .power_up_auto_run, .begin_cmd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
  .converting, .result_done);

// *** verif/tcr_host.sv ***
`timescale 1ns/1ps
module tcr_host (
  input  wire logic ref_clk,
  output logic      reg_wr = 1'b0,
  output logic [7:0] reg_addr = 8'hA8,
  output logic [7:0] reg_wdata = 8'h00
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
endmodule

// *** verif/test_tcr_temp_conversion_readout.sv ***
`timescale 1ns/1ps
module test_tcr_temp_conversion_readout;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        power_up_auto_run = 1'b1;
  logic        single_measure_select = 1'b1;
  logic [1:0]  res = 2'h3;
  logic        res_sel_wr = 1'b0;
  logic        begin_cmd = 1'b0;
  logic        halt_cmd = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  logic [15:0] s = 16'h005F;
  logic [15:0] m;
  logic [15:0] t [7] = '{16'hAAE2, 16'hAB00, 16'hA007, 16'hA180, 16'hA205, 16'hA300, 16'hA800};
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, eq [$];
  logic        reg_wr, converting, result_done;
  int          failures = 0, compares = 0, n, d [4];
  event        got;
  tcr_host u_tcr_host (.ref_clk, .reg_wr, .reg_addr, .reg_wdata);
  tcr_temp_conversion_readout #(.CONV10_CYCLES(32'h8)) u_tcr_temp_conversion_readout (
    .ref_clk, .reset_n, .clk_en, .power_up_auto_run, .single_measure_select,
    .resolution_sel_lo(res[0]), .resolution_sel_hi(res[1]), .res_sel_wr, .begin_cmd, .halt_cmd,
    .sample_in, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .converting, .result_done);
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [15:0] xs;
    s = s ^ (s << 7);
    s = s ^ (s >> 9);
    s = s ^ (s << 8);
    return s;
  endfunction
  task automatic check(input logic [15:0] v, input logic [15:0] e);
    compares++;
    if (v !== e) begin
      failures++;
      $display("Error %0t: saw %h want %h", $time, v, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    eq.push_back(e);
    u_tcr_host.xfer(1'b0, a, 8'h00);
    -> got;
  endtask
  always @(got) check({8'h00, reg_rdata}, {8'h00, eq.pop_front()});
  task automatic pulse(ref logic p);
    @(negedge ref_clk);
    p = 1'b1;
    @(negedge ref_clk);
    p = 1'b0;
  endtask
  task automatic wt;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (result_done !== 1'b1 && n < 3000);
    if (n >= 3000) failures++;
  endtask
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 7; i++) rd(t[i][15:8], t[i][7:0]);
    check({15'h0, converting}, 16'h0001);
    power_up_auto_run = 1'b0;
    wt;
    repeat (3) @(negedge ref_clk);
    check({15'h0, converting}, 16'h0000);
    $display("reset test done");
    u_tcr_host.xfer(1'b1, 8'hA0, 8'h5A);
    rd(8'hA0, 8'h5A);
    u_tcr_host.xfer(1'b1, 8'hA1, 8'hFF);
    rd(8'hA1, 8'hF8);
    $display("threshold test done");
    for (int r = 0; r < 4; r++) begin
      res = r[1:0];
      pulse(res_sel_wr);
      sample_in = xs();
      pulse(begin_cmd);
      wt;
      d[r] = n;
      if (r > 0) check(16'(d[r] - d[r-1]), 16'(8 << (r - 1)));
      m = ~((16'h0008 << (3 - r)) - 16'h0001);
      rd(8'hAA, sample_in[15:8] & m[15:8]);
      rd(8'hAB, sample_in[7:0] & m[7:0]);
    end
    $display("resolution test done");
    single_measure_select = 1'b0;
    pulse(begin_cmd);
    wt;
    wt;
    check({15'h0, converting}, 16'h0001);
    pulse(halt_cmd);
    wt;
    repeat (3) @(negedge ref_clk);
    check({15'h0, converting}, 16'h0000);
    $display("continuous test done");
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    rd(8'hAA, 8'hE2);
    rd(8'hAB, 8'h00);
    check({15'h0, converting}, 16'h0000);
    $display("second reset test done");
    single_measure_select = 1'b1;
    pulse(begin_cmd);
    repeat (4) @(negedge ref_clk);
    clk_en = 1'b0;
    repeat (100) @(negedge ref_clk);
    check({15'h0, converting}, 16'h0001);
    check({15'h0, result_done}, 16'h0000);
    clk_en = 1'b1;
    wt;
    check({15'h0, (n < 64)}, 16'h0001);
    $display("freeze test done");
    results();
  end
endmodule
